// >>> verilog/iese_pkg.sv
package iese_pkg;

	// ==========================================================
	// Register map (word offsets on the Wishbone bus)
	// ==========================================================
	localparam logic [3:0] ADR_EDGE_POL     = 4'h0;
	localparam logic [3:0] ADR_ENABLE_ONE   = 4'h1;
	localparam logic [3:0] ADR_ENABLE_TWO   = 4'h2;
	localparam logic [3:0] ADR_FLAGS_ONE    = 4'h3;
	localparam logic [3:0] ADR_FLAGS_TWO    = 4'h4;
	localparam logic [3:0] ADR_WAKE_FLAGS   = 4'h5;

	// ==========================================================
	// Reset values and fixed bits
	// ==========================================================
	localparam logic [4:0] EDGE_POL_RESET   = 5'h00;
	localparam logic [2:0] EDGE_POL_FIXED   = 3'h7;
	localparam logic [7:0] ENABLE_RESET     = 8'h00;
	localparam logic [7:0] FLAGS_ONE_FIXED  = 8'h20;

	// ==========================================================
	// Field positions, enable one
	// ==========================================================
	localparam int EN1_TIMER_A   = 7;
	localparam int EN1_RSVD      = 6;
	localparam int EN1_WAKEUP    = 5;
	localparam int EN1_EXT_HI    = 4;

	// ==========================================================
	// Field positions, enable two
	// ==========================================================
	localparam int EN2_DIRECT    = 7;
	localparam int EN2_ADC       = 6;
	localparam int EN2_RSVD      = 5;
	localparam int EN2_TIMER_G   = 4;
	localparam int EN2_TIMER_FH  = 3;
	localparam int EN2_TIMER_FL  = 2;
	localparam int EN2_TIMER_C   = 1;
	localparam int EN2_ASYNC     = 0;

	// ==========================================================
	// Peripheral event bundle
	// ==========================================================
	typedef struct packed {
		logic direct_xfer;
		logic adc_done;
		logic timer_g;
		logic timer_f_high;
		logic timer_f_low;
		logic timer_c;
		logic async_counter;
		logic timer_a;
	} iese_events_type;

	// Gated requests towards the CPU
	typedef struct packed {
		logic       direct_xfer;
		logic       adc_done;
		logic       timer_g;
		logic       timer_f_high;
		logic       timer_f_low;
		logic       timer_c;
		logic       async_counter;
		logic       timer_a;
		logic       wakeup;
		logic [4:0] ext_pin;
	} iese_requests_type;

endpackage : iese_pkg

// >>> verilog/iese_top.sv
`timescale 1ns/1ps
module iese_top
(
	// Clock and reset
	input  wire logic                        ref_clk,
	input  wire logic                        rst_n,
	// Wishbone slave
	input  wire logic                        wb_cyc_i,
	input  wire logic                        wb_stb_i,
	input  wire logic                        wb_we_i,
	input  wire logic [3:0]                  wb_adr_i,
	input  wire logic [3:0]                  wb_sel_i,
	input  wire logic [31:0]                 wb_dat_i,
	output logic      [31:0]                 wb_dat_o,
	output logic                             wb_ack_o,
	output logic                             wb_err_o,
	// External pins, asynchronous
	input  wire logic [4:0]                  ext_int_pin,
	input  wire logic                        adc_ext_trigger_pin,
	input  wire logic                        timer_f_event_pin,
	input  wire logic                        timer_c_event_pin,
	input  wire logic [7:0]                  wakeup_pin,
	// Peripheral events, same clock, one-cycle pulses
	input  wire iese_pkg::iese_events_type   periph_evt,
	// Edge strobes to peripherals
	output logic                             adc_trigger_evt,
	output logic                             timer_f_evt,
	output logic                             timer_c_evt,
	// Requests to CPU
	output iese_pkg::iese_requests_type      cpu_req
);

	// ==========================================================
	// Registers
	// ==========================================================
	logic [4:0]  edge_pol_q;
	logic [7:0]  enable_one_q;
	logic [7:0]  enable_two_q;
	logic [7:0]  flags_one_q;
	logic [7:0]  flags_two_q;
	logic [7:0]  wake_flags_q;
	logic [7:0]  rd_data;
	logic        rd_hit;
	logic        wr_lane0;
	logic        bus_req;

	// ==========================================================
	// Pin synchronisers and edge detection
	// ==========================================================
	localparam int NPIN = 16;
	logic [NPIN-1:0] pin_raw;
	logic [NPIN-1:0] pin_s1_q;
	logic [NPIN-1:0] pin_s2_q;
	logic [NPIN-1:0] pin_s3_q;
	logic [NPIN-1:0] pin_lvl_q;
	logic [NPIN-1:0] pin_rise;
	logic [NPIN-1:0] pin_fall;
	logic [NPIN-1:0] pin_pol;
	logic [NPIN-1:0] pin_edge;

	assign pin_raw = {wakeup_pin, timer_c_event_pin, timer_f_event_pin, adc_ext_trigger_pin, ext_int_pin};

	// Polarity per pin: shared bits drive the paired pins
	assign pin_pol[4:0] = edge_pol_q;
	assign pin_pol[5]   = edge_pol_q[4];
	assign pin_pol[6]   = edge_pol_q[3];
	assign pin_pol[7]   = edge_pol_q[1];
	assign pin_pol[15:8] = 8'h00;

	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			// Idle high, matches the held level so no false edge follows reset
			pin_s1_q <= '1;
			pin_s2_q <= '1;
			pin_s3_q <= '1;
		end
		else
		begin
			pin_s1_q <= pin_raw;
			pin_s2_q <= pin_s1_q;
			pin_s3_q <= pin_s2_q;
		end
	end

	// Filtered level: changes only when stages two and three agree
	genvar gi;
	generate
		for (gi = 0; gi < NPIN; gi++)
		begin : g_pin
			always_ff @(posedge ref_clk)
			begin
				if (!rst_n)
					pin_lvl_q[gi] <= 1'b1;
				else if (pin_s2_q[gi] == pin_s3_q[gi])
					pin_lvl_q[gi] <= pin_s3_q[gi];
			end
			assign pin_rise[gi] = (pin_s2_q[gi] == pin_s3_q[gi]) && pin_s3_q[gi] && !pin_lvl_q[gi];
			assign pin_fall[gi] = (pin_s2_q[gi] == pin_s3_q[gi]) && !pin_s3_q[gi] && pin_lvl_q[gi];
			assign pin_edge[gi] = pin_pol[gi] ? pin_rise[gi] : pin_fall[gi];
		end
	endgenerate

	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			adc_trigger_evt <= 1'b0;
			timer_f_evt     <= 1'b0;
			timer_c_evt     <= 1'b0;
		end
		else
		begin
			adc_trigger_evt <= pin_edge[5];
			timer_f_evt     <= pin_edge[6];
			timer_c_evt     <= pin_edge[7];
		end
	end

	// ==========================================================
	// Wishbone slave
	// ==========================================================
	assign bus_req  = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
	assign wr_lane0 = bus_req && wb_we_i && wb_sel_i[0] && rd_hit;

	always_comb
	begin
		rd_hit  = 1'b1;
		rd_data = 8'h00;
		unique case (wb_adr_i)
			iese_pkg::ADR_EDGE_POL:   rd_data = {iese_pkg::EDGE_POL_FIXED, edge_pol_q};
			iese_pkg::ADR_ENABLE_ONE: rd_data = enable_one_q;
			iese_pkg::ADR_ENABLE_TWO: rd_data = enable_two_q;
			iese_pkg::ADR_FLAGS_ONE:  rd_data = flags_one_q | iese_pkg::FLAGS_ONE_FIXED;
			iese_pkg::ADR_FLAGS_TWO:  rd_data = flags_two_q;
			iese_pkg::ADR_WAKE_FLAGS: rd_data = wake_flags_q;
			default:                  rd_hit  = 1'b0;
		endcase
	end

	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			wb_ack_o <= 1'b0;
			wb_err_o <= 1'b0;
			wb_dat_o <= '0;
		end
		else
		begin
			wb_ack_o <= bus_req && rd_hit;
			wb_err_o <= bus_req && !rd_hit;
			wb_dat_o <= (bus_req && rd_hit && !wb_we_i) ? {24'h000000, rd_data} : 32'h00000000;
		end
	end

	// ==========================================================
	// Edge polarity and enable registers
	// ==========================================================
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
			edge_pol_q <= iese_pkg::EDGE_POL_RESET;
		else if (wr_lane0 && wb_adr_i == iese_pkg::ADR_EDGE_POL)
			edge_pol_q <= wb_dat_i[4:0];
	end

	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
			enable_one_q <= iese_pkg::ENABLE_RESET;
		else if (wr_lane0 && wb_adr_i == iese_pkg::ADR_ENABLE_ONE)
			enable_one_q <= wb_dat_i[7:0];
	end

	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
			enable_two_q <= iese_pkg::ENABLE_RESET;
		else if (wr_lane0 && wb_adr_i == iese_pkg::ADR_ENABLE_TWO)
			enable_two_q <= wb_dat_i[7:0];
	end

	// ==========================================================
	// Sticky request flags: write 0 clears, set wins
	// ==========================================================
	logic [7:0] set_one;
	logic [7:0] set_two;
	logic [7:0] clr_one;
	logic [7:0] clr_two;
	logic [7:0] clr_wake;

	assign set_one  = {periph_evt.timer_a, 2'b00, pin_edge[4:0]};
	assign set_two  = {periph_evt.direct_xfer, periph_evt.adc_done, 1'b0, periph_evt.timer_g,
		periph_evt.timer_f_high, periph_evt.timer_f_low, periph_evt.timer_c, periph_evt.async_counter};
	assign clr_one  = (wr_lane0 && wb_adr_i == iese_pkg::ADR_FLAGS_ONE)  ? ~wb_dat_i[7:0] : 8'h00;
	assign clr_two  = (wr_lane0 && wb_adr_i == iese_pkg::ADR_FLAGS_TWO)  ? ~wb_dat_i[7:0] : 8'h00;
	assign clr_wake = (wr_lane0 && wb_adr_i == iese_pkg::ADR_WAKE_FLAGS) ? ~wb_dat_i[7:0] : 8'h00;

	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
			flags_one_q <= 8'h00;
		else
		begin
			flags_one_q <= (flags_one_q & ~clr_one) | set_one;
			// Bit 6 is plain storage, bit 5 reads fixed one
			if (wr_lane0 && wb_adr_i == iese_pkg::ADR_FLAGS_ONE)
				flags_one_q[6] <= wb_dat_i[6];
			flags_one_q[5] <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
			flags_two_q <= 8'h00;
		else
		begin
			flags_two_q <= (flags_two_q & ~clr_two) | set_two;
			if (wr_lane0 && wb_adr_i == iese_pkg::ADR_FLAGS_TWO)
				flags_two_q[5] <= wb_dat_i[5];
		end
	end

	// Wakeup pins always sense falling edges
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
			wake_flags_q <= 8'h00;
		else
			wake_flags_q <= (wake_flags_q & ~clr_wake) | pin_fall[15:8];
	end

	// ==========================================================
	// Gated requests to the CPU
	// ==========================================================
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
			cpu_req <= '0;
		else
		begin
			cpu_req.timer_a       <= flags_one_q[7] && enable_one_q[iese_pkg::EN1_TIMER_A];
			cpu_req.wakeup        <= |wake_flags_q && enable_one_q[iese_pkg::EN1_WAKEUP];
			cpu_req.ext_pin       <= flags_one_q[4:0] & enable_one_q[iese_pkg::EN1_EXT_HI:0];
			cpu_req.direct_xfer   <= flags_two_q[7] && enable_two_q[iese_pkg::EN2_DIRECT];
			cpu_req.adc_done      <= flags_two_q[6] && enable_two_q[iese_pkg::EN2_ADC];
			cpu_req.timer_g       <= flags_two_q[4] && enable_two_q[iese_pkg::EN2_TIMER_G];
			cpu_req.timer_f_high  <= flags_two_q[3] && enable_two_q[iese_pkg::EN2_TIMER_FH];
			cpu_req.timer_f_low   <= flags_two_q[2] && enable_two_q[iese_pkg::EN2_TIMER_FL];
			cpu_req.timer_c       <= flags_two_q[1] && enable_two_q[iese_pkg::EN2_TIMER_C];
			cpu_req.async_counter <= flags_two_q[0] && enable_two_q[iese_pkg::EN2_ASYNC];
		end
	end

endmodule : iese_top

// >>> verification/iese_top_assertions.sv
`timescale 1ns/1ps
module iese_chk
(
	// Clock and reset
	input wire logic                        ref_clk,
	input wire logic                        rst_n,
	// Register bus
	input wire logic                        wb_cyc_i,
	input wire logic                        wb_stb_i,
	input wire logic                        wb_we_i,
	input wire logic [3:0]                  wb_adr_i,
	input wire logic [3:0]                  wb_sel_i,
	input wire logic [31:0]                 wb_dat_i,
	input wire logic [31:0]                 wb_dat_o,
	input wire logic                        wb_ack_o,
	input wire logic                        wb_err_o,
	// Pins, events, results
	input wire logic                        timer_c_event_pin,
	input wire iese_pkg::iese_events_type   periph_evt,
	input wire logic                        timer_c_evt,
	input wire iese_pkg::iese_requests_type cpu_req
);
	// ====================
	// Register shadows
	logic       take;
	logic [7:0] pol_q;
	logic [7:0] en1_q;
	logic [7:0] en2_q;
	assign take = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			pol_q <= 8'h00;
			en1_q <= 8'h00;
			en2_q <= 8'h00;
		end
		else if (take && wb_we_i && wb_sel_i[0])
		begin
			if (wb_adr_i == 4'h0)
				pol_q <= wb_dat_i[7:0];
			if (wb_adr_i == 4'h1)
				en1_q <= wb_dat_i[7:0];
			if (wb_adr_i == 4'h2)
				en2_q <= wb_dat_i[7:0];
		end
	end
	// ====================
	// Properties
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	property p_ack_once;
		wb_ack_o |=> !wb_ack_o;
	endproperty
	a_ack_once: assert property (p_ack_once) else $error("ack longer than one cycle");
	property p_answer;
		take |=> (wb_ack_o ^ wb_err_o);
	endproperty
	a_answer: assert property (p_answer) else $error("no single answer");
	property p_unmapped;
		take && wb_adr_i > 4'h5 |=> wb_err_o && wb_dat_o == 32'h00000000;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped not refused");
	property p_pol_read;
		take && !wb_we_i && wb_adr_i == 4'h0 |=> wb_dat_o[7:0] == {3'h7, pol_q[4:0]};
	endproperty
	a_pol_read: assert property (p_pol_read) else $error("edge register readback");
	property p_en_read;
		take && !wb_we_i && (wb_adr_i == 4'h1 || wb_adr_i == 4'h2)
			|=> wb_dat_o[7:0] == (($past(wb_adr_i) == 4'h2) ? en2_q : en1_q);
	endproperty
	a_en_read: assert property (p_en_read) else $error("enable readback");
	property p_gate_one;
		(cpu_req[6:0] & ~$past({en1_q[7], en1_q[5:0]})) == 7'h00;
	endproperty
	a_gate_one: assert property (p_gate_one) else $error("request one not gated");
	property p_gate_two;
		1'b1 |=> (cpu_req[13:7] & ~$past({en2_q[7:6], en2_q[4:0]})) == 7'h00;
	endproperty
	a_gate_two: assert property (p_gate_two) else $error("request two not gated");
	property p_evt_req;
		periph_evt.adc_done && en2_q[6] ##1 en2_q[6] |=> cpu_req.adc_done;
	endproperty
	a_evt_req: assert property (p_evt_req) else $error("adc request missing");
	property p_pin_strobe;
		(pol_q[1] ? $rose(timer_c_event_pin) : $fell(timer_c_event_pin)) |-> ##[2:5] timer_c_evt;
	endproperty
	a_pin_strobe: assert property (p_pin_strobe) else $error("timer c strobe missing");
	property p_wrong_edge;
		(pol_q[1] ? $fell(timer_c_event_pin) : $rose(timer_c_event_pin)) |-> ##1 !timer_c_evt [*5];
	endproperty
	a_wrong_edge: assert property (p_wrong_edge) else $error("timer c strobe on wrong edge");
endmodule : iese_chk
bind iese_top iese_chk u_chk (.ref_clk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
	.wb_dat_o, .wb_ack_o, .wb_err_o, .timer_c_event_pin, .periph_evt, .timer_c_evt, .cpu_req);

// >>> verification/iese_src_model.sv
`timescale 1ns/1ps
module iese_src_model
(
	// Clock
	input wire logic                  ref_clk,
	// Pins, idle high
	output logic [15:0]               pins,
	// Peripheral pulses
	output iese_pkg::iese_events_type evt
);
	initial
	begin
		pins = 16'hFFFF;
		evt = '0;
	end
	task automatic drive(input logic [15:0] v);
		@(posedge ref_clk);
		pins <= v;
	endtask : drive
	task automatic pulse(input logic [7:0] v);
		@(posedge ref_clk);
		evt <= v;
		@(posedge ref_clk);
		evt <= '0;
	endtask : pulse
endmodule : iese_src_model

// >>> verification/test_int_edge_select_and_enable.sv
`timescale 1ns/1ps
module test_int_edge_select_and_enable;
	logic                        ref_clk, rst_n, cyc, stb, we, ack, err, e, trig, tf, tc;
	logic [3:0]                  adr, sel;
	logic [31:0]                 dat, rdat, q;
	logic [15:0]                 pins;
	logic [11:0]                 cnt;
	iese_pkg::iese_events_type   evt;
	iese_pkg::iese_requests_type req;
	int                          errors, compares;
	iese_top u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(err),
		.ext_int_pin(pins[4:0]), .adc_ext_trigger_pin(pins[5]), .timer_f_event_pin(pins[6]),
		.timer_c_event_pin(pins[7]), .wakeup_pin(pins[15:8]), .periph_evt(evt), .adc_trigger_evt(trig),
		.timer_f_evt(tf), .timer_c_evt(tc), .cpu_req(req));
	iese_src_model u_src (.ref_clk(ref_clk), .pins(pins), .evt(evt));
	initial
	begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end
	// Strobe counts: adc trigger, timer f, timer c
	always_ff @(posedge ref_clk)
		cnt <= !rst_n ? 12'h000 : cnt + {3'h0, trig, 3'h0, tf, 3'h0, tc};
	// ====================
	// Bus and compare tasks
	task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
		compares++;
		if (g !== x)
		begin
			errors++;
			$display("BAD %s exp %h got %h", n, x, g);
		end
	endtask : chk
	task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge ref_clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= {24'h000000, d};
		@(posedge ref_clk);
		while (ack !== 1'b1 && err !== 1'b1 && n < 20)
		begin
			@(posedge ref_clk);
			n++;
		end
		if (n >= 20)
		begin
			errors++;
			$display("BAD bus no answer exp ack got none");
		end
		q = rdat;
		e = err;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask : wb
	task automatic rd(input logic [3:0] a, input logic [7:0] x);
		wb(1'b0, a, 8'h00);
		chk("reg", {24'h000000, x}, q);
	endtask : rd
	task automatic pin_case(input logic [7:0] p, input logic [15:0] v, input logic [7:0] f, input logic [7:0] w,
		input logic [11:0] c);
		wb(1'b1, 4'h0, p);
		u_src.drive(v);
		repeat (8) @(posedge ref_clk);
		chk("req", {26'h0, |w, f[4:0]}, {18'h0, req});
		rd(4'h3, f);
		rd(4'h5, w);
		chk("cnt", {20'h0, c}, {20'h0, cnt});
		wb(1'b1, 4'h3, 8'h00);
		wb(1'b1, 4'h5, 8'h00);
	endtask : pin_case
	task automatic final_report;
		$display("errors %0d compares %0d", errors, compares);
		if (errors == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : final_report
	initial
	begin
		repeat (20000) @(posedge ref_clk);
		errors++;
		final_report();
	end
	// ====================
	// Tests
	initial
	begin
		{rst_n, cyc, stb, we, adr, dat, errors, compares} = '0;
		sel = 4'hF;
		repeat (5) @(posedge ref_clk);
		rst_n <= 1'b1;
		rd(4'h0, 8'hE0);
		rd(4'h1, 8'h00);
		rd(4'h2, 8'h00);
		wb(1'b1, 4'h0, 8'hFF);
		rd(4'h0, 8'hFF);
		wb(1'b1, 4'h0, 8'h00);
		rd(4'h0, 8'hE0);
		wb(1'b1, 4'h1, 8'hFF);
		wb(1'b1, 4'h2, 8'hFF);
		rd(4'h1, 8'hFF);
		rd(4'h2, 8'hFF);
		sel <= 4'h0;
		wb(1'b1, 4'h1, 8'h00);
		sel <= 4'hF;
		rd(4'h1, 8'hFF);
		wb(1'b0, 4'h7, 8'h00);
		chk("err", 32'h1, {31'h0, e});
		wb(1'b1, 4'hF, 8'hFF);
		chk("err", 32'h1, {31'h0, e});
		wb(1'b1, 4'h1, 8'h00);
		wb(1'b1, 4'h2, 8'h00);
		u_src.pulse(8'hFF);
		repeat (3) @(posedge ref_clk);
		chk("req", 32'h0, {18'h0, req});
		rd(4'h3, 8'hA0);
		rd(4'h4, 8'hDF);
		wb(1'b1, 4'h1, 8'h80);
		wb(1'b1, 4'h2, 8'hDF);
		repeat (2) @(posedge ref_clk);
		chk("req", 32'h3FC0, {18'h0, req});
		wb(1'b1, 4'h4, 8'hDF);
		rd(4'h4, 8'hDF);
		wb(1'b1, 4'h4, 8'h00);
		wb(1'b1, 4'h3, 8'h00);
		rd(4'h4, 8'h00);
		rd(4'h3, 8'h20);
		chk("req", 32'h0, {18'h0, req});
		u_src.pulse(8'hFF);
		repeat (3) @(posedge ref_clk);
		chk("req", 32'h3FC0, {18'h0, req});
		wb(1'b1, 4'h4, 8'h00);
		wb(1'b1, 4'h3, 8'h00);
		wb(1'b1, 4'h1, 8'h3F);
		pin_case(8'h00, 16'h0000, 8'h3F, 8'hFF, 12'h111);
		pin_case(8'h00, 16'hFFFF, 8'h20, 8'h00, 12'h111);
		pin_case(8'h1F, 16'h0000, 8'h20, 8'hFF, 12'h111);
		pin_case(8'h1F, 16'hFFFF, 8'h3F, 8'h00, 12'h222);
		pin_case(8'h0A, 16'h0000, 8'h35, 8'hFF, 12'h322);
		pin_case(8'h0A, 16'hFFFF, 8'h2A, 8'h00, 12'h333);
		final_report();
	end
endmodule : test_int_edge_select_and_enable
